/* File: design/fwg_pkg.sv */
// Package: flash command codes, query offsets, expected query words, bus timing
package fwg_pkg;
   // Bus widths
   localparam int ADDR_W = 22;
   localparam int DATA_W = 16;
   // Clock and bus timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int STROBE_NS = 40;
   localparam int SETUP_NS = 12;
   localparam int HOLD_NS = 20;
   localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8;
   // Unlock and command cycles
   localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 22'h000555;
   localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 22'h0002aa;
   localparam logic [DATA_W-1:0] UNLOCK1_DATA = 16'h00aa;
   localparam logic [DATA_W-1:0] UNLOCK2_DATA = 16'h0055;
   localparam logic [DATA_W-1:0] CMD_ENTER_SECURED = 16'h0088;
   localparam logic [DATA_W-1:0] CMD_EXIT_SECURED = 16'h0090;
   localparam logic [DATA_W-1:0] CMD_EXIT_SECURED2 = 16'h0000;
   localparam logic [DATA_W-1:0] CMD_PROGRAM = 16'h00a0;
   localparam logic [DATA_W-1:0] CMD_RESET = 16'h00f0;
   localparam logic [ADDR_W-1:0] QUERY_ADDR = 22'h000055;
   localparam logic [DATA_W-1:0] CMD_QUERY = 16'h0098;
   // Query table window
   localparam logic [ADDR_W-1:0] QRY_FIRST = 22'h000010;
   localparam logic [ADDR_W-1:0] QRY_LAST = 22'h000026;
   localparam int QRY_N = 23;
   localparam logic [DATA_W-1:0] QRY_TABLE [QRY_N] = '{
      16'h0051, 16'h0052, 16'h0059, 16'h0002, 16'h0000, 16'h0040, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0027, 16'h0036, 16'h0000,
      16'h0000, 16'h0004, 16'h0000, 16'h000a, 16'h0000, 16'h0005, 16'h0000,
      16'h0004, 16'h0000};
   // Host operations
   typedef enum logic [2:0] {
      FWG_OP_READ = 3'h0,
      FWG_OP_QUERY = 3'h1,
      FWG_OP_QUERY_EXIT = 3'h2,
      FWG_OP_ENTER_SEC = 3'h3,
      FWG_OP_EXIT_SEC = 3'h4,
      FWG_OP_PROGRAM = 3'h5,
      FWG_OP_RAW_WRITE = 3'h6
   } fwg_op_t;
endpackage

/* File: design/fwg_cyc_if.sv */
// Interface: one bus cycle request between sequencer and pin engine
`timescale 1ns/1ns
interface fwg_cyc_if;
   import fwg_pkg::*;
   logic req;
   logic wr;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic done;
   logic [DATA_W-1:0] rdata;
   modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
   modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

/* File: design/fwg_cyc_eng.sv */
// Pin engine: one chip-enable controlled read or write cycle on the flash pins
`timescale 1ns/1ns
module fwg_cyc_eng
   import fwg_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Cycle request
   fwg_cyc_if.eng cyc,
   // Flash pins
   input wire logic [DATA_W-1:0] i_dq_sync,
   output logic [ADDR_W-1:0] o_addr,
   output logic [DATA_W-1:0] o_dq,
   output logic o_dq_oe,
   output logic o_ce_n,
   output logic o_we_n,
   output logic o_oe_n
);
   typedef enum logic [1:0] {E_IDLE = 2'b00, E_SETUP = 2'b01, E_STROBE = 2'b11, E_HOLD = 2'b10}
      fwg_eng_t;
   fwg_eng_t st_q;
   logic [CNT_W-1:0] cnt_q;
   logic wr_q;

   // ****************************************
   // Cycle timing
   // ****************************************
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_q <= E_IDLE;
         cnt_q <= '0;
         wr_q <= 1'b0;
      end else begin
         case (st_q)
            E_IDLE: begin
               if (cyc.req) begin
                  wr_q <= cyc.wr;
                  cnt_q <= CNT_W'(SETUP_CYC);
                  st_q <= E_SETUP;
               end
            end
            E_SETUP: begin
               if (cnt_q <= 8'h01) begin
                  cnt_q <= CNT_W'(STROBE_CYC);
                  st_q <= E_STROBE;
               end else cnt_q <= cnt_q - 8'h01;
            end
            E_STROBE: begin
               if (cnt_q <= 8'h01) begin
                  cnt_q <= CNT_W'(HOLD_CYC);
                  st_q <= E_HOLD;
               end else cnt_q <= cnt_q - 8'h01;
            end
            E_HOLD: begin
               if (cnt_q <= 8'h01) st_q <= E_IDLE;
               else cnt_q <= cnt_q - 8'h01;
            end
            default: st_q <= E_IDLE;
         endcase
      end
   end

   // ****************************************
   // Pin drive
   // ****************************************
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_addr <= '0;
         o_dq <= '0;
         o_dq_oe <= 1'b0;
         o_ce_n <= 1'b1;
         o_we_n <= 1'b1;
         o_oe_n <= 1'b1;
      end else begin
         if (st_q == E_IDLE && cyc.req) begin
            o_addr <= cyc.addr;
            o_dq <= cyc.wdata;
            o_dq_oe <= cyc.wr;
            o_oe_n <= 1'b1;
            o_we_n <= !cyc.wr;
         end
         if (st_q == E_SETUP && cnt_q <= 8'h01) begin
            o_ce_n <= 1'b0;
            o_oe_n <= wr_q;
         end
         if (st_q == E_STROBE && cnt_q <= 8'h01) begin
            o_ce_n <= 1'b1;
            o_oe_n <= 1'b1;
         end
         if (st_q == E_HOLD && cnt_q <= 8'h01) begin
            o_dq_oe <= 1'b0;
            o_we_n <= 1'b1;
         end
      end
   end

   // ****************************************
   // Completion and read capture
   // ****************************************
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cyc.done <= 1'b0;
         cyc.rdata <= '0;
      end else begin
         cyc.done <= (st_q == E_HOLD && cnt_q <= 8'h01);
         // Sampled late in strobe; sync adds two cycles, so strobe covers it
         if (st_q == E_STROBE && cnt_q <= 8'h01 && !wr_q) cyc.rdata <= i_dq_sync;
      end
   end
endmodule // fwg_cyc_eng

/* File: design/fwg_host.sv */
// Host controller: command sequences and query readout for the flash write guard
`timescale 1ns/1ns
module fwg_host
   import fwg_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Command port
   input wire logic i_op_valid,
   input wire fwg_op_t i_op,
   input wire logic [ADDR_W-1:0] i_op_addr,
   input wire logic [DATA_W-1:0] i_op_data,
   output logic o_op_ready,
   output logic o_rd_valid,
   output logic [DATA_W-1:0] o_rd_data,
   output logic o_query_ok,
   output logic o_query_mode,
   output logic o_secured_mode,
   // Flash pins
   input wire logic [DATA_W-1:0] i_dq,
   output logic [ADDR_W-1:0] o_addr,
   output logic [DATA_W-1:0] o_dq,
   output logic o_dq_oe,
   output logic o_ce_n,
   output logic o_we_n,
   output logic o_oe_n
);
   typedef enum logic [1:0] {S_IDLE = 2'b00, S_ISSUE = 2'b01, S_WAIT = 2'b11, S_NEXT = 2'b10}
      fwg_seq_t;
   localparam int STEP_W = 5;

   fwg_seq_t st_q;
   fwg_op_t op_q;
   logic [ADDR_W-1:0] addr_q;
   logic [DATA_W-1:0] data_q;
   logic [STEP_W-1:0] step_q;
   logic [STEP_W-1:0] last_step;
   logic [DATA_W-1:0] dq_meta_q;
   logic [DATA_W-1:0] dq_sync_q;
   logic qok_q;
   logic cyc_wr;
   logic [ADDR_W-1:0] cyc_addr;
   logic [DATA_W-1:0] cyc_data;
   fwg_cyc_if cyc ();

   // ****************************************
   // Data pin synchroniser
   // ****************************************
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         dq_meta_q <= '0;
         dq_sync_q <= '0;
      end else begin
         dq_meta_q <= i_dq;
         dq_sync_q <= dq_meta_q;
      end
   end

   // ****************************************
   // Cycle list per operation
   // ****************************************
   always_comb begin
      cyc_wr = 1'b1;
      cyc_addr = UNLOCK1_ADDR;
      cyc_data = UNLOCK1_DATA;
      last_step = '0;
      case (op_q)
         FWG_OP_READ: begin
            cyc_wr = 1'b0;
            cyc_addr = addr_q;
         end
         FWG_OP_QUERY: begin
            last_step = STEP_W'(QRY_N);
            if (step_q == '0) begin
               cyc_addr = QUERY_ADDR;
               cyc_data = CMD_QUERY;
            end else begin
               cyc_wr = 1'b0;
               cyc_addr = QRY_FIRST + ADDR_W'(step_q - 5'd1);
            end
         end
         FWG_OP_QUERY_EXIT, FWG_OP_RAW_WRITE: begin
            cyc_addr = (op_q == FWG_OP_RAW_WRITE) ? addr_q : '0;
            cyc_data = (op_q == FWG_OP_RAW_WRITE) ? data_q : CMD_RESET;
         end
         default: begin
            last_step = (op_q == FWG_OP_EXIT_SEC || op_q == FWG_OP_PROGRAM) ? 5'd3 : 5'd2;
            case (step_q)
               5'd0: ;
               5'd1: begin
                  cyc_addr = UNLOCK2_ADDR;
                  cyc_data = UNLOCK2_DATA;
               end
               5'd2: begin
                  cyc_data = (op_q == FWG_OP_ENTER_SEC) ? CMD_ENTER_SECURED :
                             (op_q == FWG_OP_EXIT_SEC) ? CMD_EXIT_SECURED : CMD_PROGRAM;
               end
               default: begin
                  cyc_addr = (op_q == FWG_OP_PROGRAM) ? addr_q : '0;
                  cyc_data = (op_q == FWG_OP_PROGRAM) ? data_q : CMD_EXIT_SECURED2;
               end
            endcase
         end
      endcase
   end

   assign cyc.req = (st_q == S_ISSUE);
   assign cyc.wr = cyc_wr;
   assign cyc.addr = cyc_addr;
   assign cyc.wdata = cyc_data;

   // ****************************************
   // Sequencer
   // ****************************************
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_q <= S_IDLE;
         op_q <= FWG_OP_READ;
         addr_q <= '0;
         data_q <= '0;
         step_q <= '0;
         o_op_ready <= 1'b0;
      end else begin
         case (st_q)
            S_IDLE: begin
               o_op_ready <= 1'b1;
               if (i_op_valid && o_op_ready) begin
                  op_q <= i_op;
                  addr_q <= i_op_addr;
                  data_q <= i_op_data;
                  step_q <= '0;
                  o_op_ready <= 1'b0;
                  st_q <= S_ISSUE;
               end
            end
            S_ISSUE: st_q <= S_WAIT;
            S_WAIT: if (cyc.done) st_q <= S_NEXT;
            S_NEXT: begin
               if (step_q == last_step) st_q <= S_IDLE;
               else begin
                  step_q <= step_q + 5'd1;
                  st_q <= S_ISSUE;
               end
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end

   // ****************************************
   // Read return and query check
   // ****************************************
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_rd_valid <= 1'b0;
         o_rd_data <= '0;
         qok_q <= 1'b1;
         o_query_ok <= 1'b0;
      end else begin
         o_rd_valid <= (st_q == S_WAIT && cyc.done && !cyc_wr);
         if (st_q == S_WAIT && cyc.done && !cyc_wr) o_rd_data <= cyc.rdata;
         if (st_q == S_IDLE && i_op_valid && o_op_ready && i_op == FWG_OP_QUERY) begin
            qok_q <= 1'b1;
            o_query_ok <= 1'b0;
         end
         if (st_q == S_WAIT && cyc.done && op_q == FWG_OP_QUERY && step_q != '0 &&
             cyc.rdata != QRY_TABLE[step_q - 5'd1]) begin
            qok_q <= 1'b0;
         end
         if (st_q == S_NEXT && op_q == FWG_OP_QUERY && step_q == last_step) o_query_ok <= qok_q;
      end
   end

   // ****************************************
   // Mode tracking
   // ****************************************
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_query_mode <= 1'b0;
         o_secured_mode <= 1'b0;
      end else if (st_q == S_NEXT && step_q == last_step) begin
         if (op_q == FWG_OP_QUERY) o_query_mode <= 1'b1;
         else if (op_q == FWG_OP_QUERY_EXIT) o_query_mode <= 1'b0;
         if (op_q == FWG_OP_ENTER_SEC) o_secured_mode <= 1'b1;
         else if (op_q == FWG_OP_EXIT_SEC) o_secured_mode <= 1'b0;
      end
   end

   fwg_cyc_eng u_eng (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .cyc(cyc),
      .i_dq_sync(dq_sync_q),
      .o_addr(o_addr),
      .o_dq(o_dq),
      .o_dq_oe(o_dq_oe),
      .o_ce_n(o_ce_n),
      .o_we_n(o_we_n),
      .o_oe_n(o_oe_n)
   );
endmodule // fwg_host

/* File: verification/fwg_flash_model.sv */
// Behavioural flash device: command register, query table, secured region, write guards
`timescale 1ns/1ns
module fwg_flash_model
   import fwg_pkg::*;
#(
   // Arbitrary autoselect word, not a real maker code
   parameter logic [15:0] AUTO_WORD = 16'h00c3
)
(
   // Flash pins
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_dq,
   input wire logic i_ce_n,
   input wire logic i_we_n,
   input wire logic i_oe_n,
   // Supply above lockout threshold
   input wire logic i_supply_ok,
   output logic [DATA_W-1:0] o_dq
);
   localparam logic [15:0] QTAB [23] = '{16'h0051, 16'h0052, 16'h0059, 16'h0002, 16'h0000,
      16'h0040, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0027, 16'h0036,
      16'h0000, 16'h0000, 16'h0004, 16'h0000, 16'h000a, 16'h0000, 16'h0005, 16'h0000,
      16'h0004, 16'h0000};
   logic [15:0] mem [int];
   int mode = 0;
   int back = 0;
   int step = 0;
   bit prog = 0;
   bit armed = 0;
   time t0 = 0;
   logic [ADDR_W-1:0] a_q;
   logic [15:0] last_q = 16'h0000;
   // write only with ce and we low, oe high
   wire wr_act = !i_ce_n && !i_we_n && i_oe_n;
   wire rd_en = !i_ce_n && !i_oe_n;
   function automatic logic [15:0] serial_word(input int i);
      return 16'h3c00 ^ i[15:0];
   endfunction
   function automatic logic [15:0] rd_word(input logic [ADDR_W-1:0] a);
      if (mode == 1) return (a >= 22'h10 && a <= 22'h26) ? QTAB[a - 22'h10] : 16'h0000;
      if (mode == 2) return AUTO_WORD;
      if (mode == 3 && a < 22'h8) return serial_word(int'(a));
      return mem.exists(int'(a)) ? mem[int'(a)] : a[15:0] ^ 16'h5a5a;
   endfunction
   task automatic take(input logic [ADDR_W-1:0] a, input logic [15:0] d);
      if (mode == 1) begin
         if (d == 16'h00f0) mode = back;
      // program after unlock, locked region untouched
      end else if (prog) begin
         prog = 0;
         if (mode != 3) mem[int'(a)] = rd_word(a) & d;
      end else if (step == 0 && a == 22'h55 && d == 16'h0098 && mode != 3) begin
         back = mode;
         mode = 1;
      end else if (step == 0) begin
         step = (a == 22'h555 && d == 16'h00aa) ? 1 : 0;
         if (d == 16'h00f0 && mode == 2) mode = 0;
      end else if (step == 1) begin
         step = (a == 22'h2aa && d == 16'h0055) ? 2 : 0;
      end else if (step == 2 && a == 22'h555) begin
         step = (d == 16'h0090 && mode == 3) ? 3 : 0;
         if (d == 16'h0088) mode = 3;
         if (d == 16'h0090 && mode != 3) mode = 2;
         prog = (d == 16'h00a0);
      end else begin
         if (step == 3 && d == 16'h0000) mode = 0;
         step = 0;
      end
   endtask
   // address at write start; a write already open at power-up is never armed
   always @(posedge wr_act) begin
      a_q = i_addr;
      t0 = $time;
      armed = i_supply_ok;
   end
   // data at write end; short pulses and lockout ignored
   always @(negedge wr_act) begin
      if (armed && i_supply_ok && $time - t0 >= 5) take(a_q, i_dq);
      armed = 0;
   end
   always @(negedge i_supply_ok) begin
      mode = 0;
      step = 0;
      prog = 0;
   end
   // Released bus shows the inverse so stale data never matches by luck
   always @* if (rd_en) last_q = rd_word(i_addr);
   assign o_dq = rd_en ? rd_word(i_addr) : ~last_q;
endmodule // fwg_flash_model

/* File: verification/fwg_host_properties.sv */
// Checker: pin-level guards of the flash host controller
`timescale 1ns/1ns
module fwg_host_properties
   import fwg_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Command side
   input wire logic o_op_ready,
   input wire logic o_rd_valid,
   // Flash pins
   input wire logic [ADDR_W-1:0] o_addr,
   input wire logic [DATA_W-1:0] o_dq,
   input wire logic o_dq_oe,
   input wire logic o_ce_n,
   input wire logic o_we_n,
   input wire logic o_oe_n
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   // Strobe low long enough to pass any glitch filter
   sequence ce_low_s;
      !o_ce_n [*8];
   endsequence
   sequence we_hold_s;
      (!o_we_n && o_dq_oe) [*3];
   endsequence
   write_oe_high_a: assert property (!o_ce_n && !o_we_n |-> o_oe_n)
      else $error("write with oe low");
   no_bus_fight_a: assert property (!o_oe_n |-> !o_dq_oe && o_we_n)
      else $error("read overlaps write drive");
   write_pins_stable_a: assert property (
      !o_ce_n && !o_we_n && $past(!o_ce_n && !o_we_n) |-> $stable(o_addr) && $stable(o_dq))
      else $error("address or data moved in write");
   strobe_width_a: assert property ($fell(o_ce_n) |=> ce_low_s)
      else $error("chip enable pulse too short");
   setup_before_ce_a: assert property (
      $fell(o_ce_n) && o_oe_n |-> $past(!o_we_n && o_dq_oe, 2))
      else $error("write setup missing");
   data_hold_a: assert property ($rose(o_ce_n) && !o_we_n |-> we_hold_s)
      else $error("write hold missing");
   idle_pins_a: assert property (
      o_op_ready |-> o_ce_n && o_we_n && o_oe_n && !o_dq_oe)
      else $error("pins active while idle");
   rd_pulse_a: assert property (o_rd_valid |=> !o_rd_valid)
      else $error("read valid longer than one cycle");
endmodule // fwg_host_properties

/* File: verification/test_fwg_host.sv */
// Testbench: flash host controller against the behavioural flash device
`timescale 1ns/1ns
module test_fwg_host;
   import fwg_pkg::*;
   logic i_clk = 1'b0;
   logic i_rstn, i_op_valid, supply_ok;
   fwg_op_t i_op;
   logic [ADDR_W-1:0] i_op_addr, o_addr, ra;
   logic [DATA_W-1:0] i_op_data, o_rd_data, o_dq, fl_dq, rd_d;
   logic o_op_ready, o_rd_valid, o_query_ok, o_query_mode, o_secured_mode;
   logic o_dq_oe, o_ce_n, o_we_n, o_oe_n;
   wire [DATA_W-1:0] dq_bus = o_dq_oe ? o_dq : fl_dq;
   logic [DATA_W-1:0] exp_q [$];
   int errors = 0;
   int checks = 0;
   int cyc = 0;
   int seed = 3799;
   int i;

   initial forever #2 i_clk = ~i_clk;

   fwg_host uut (.i_clk(i_clk), .i_rstn(i_rstn), .i_op_valid(i_op_valid), .i_op(i_op),
      .i_op_addr(i_op_addr), .i_op_data(i_op_data), .o_op_ready(o_op_ready),
      .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_query_ok(o_query_ok),
      .o_query_mode(o_query_mode), .o_secured_mode(o_secured_mode), .i_dq(dq_bus),
      .o_addr(o_addr), .o_dq(o_dq), .o_dq_oe(o_dq_oe), .o_ce_n(o_ce_n), .o_we_n(o_we_n),
      .o_oe_n(o_oe_n));
   fwg_flash_model flash (.i_addr(o_addr), .i_dq(dq_bus), .i_ce_n(o_ce_n), .i_we_n(o_we_n),
      .i_oe_n(o_oe_n), .i_supply_ok(supply_ok), .o_dq(fl_dq));

   function automatic logic [DATA_W-1:0] initv(input logic [ADDR_W-1:0] a);
      return a[15:0] ^ 16'h5a5a;
   endfunction
   task automatic cmp16(input string n, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] s);
      checks++;
      if (s !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic cmp1(input string n, input logic e, input logic s);
      checks++;
      if (s !== e) begin
         errors++;
         $display("[FAIL] %s expected %b seen %b", n, e, s);
      end
   endtask
   task automatic report_and_stop;
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Request held until taken, then wait for idle again
   task automatic do_op(input fwg_op_t op, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d);
      i_op_valid <= 1'b1;
      i_op <= op;
      i_op_addr <= a;
      i_op_data <= d;
      do @(posedge i_clk); while (o_op_ready !== 1'b1);
      i_op_valid <= 1'b0;
      do @(posedge i_clk); while (o_op_ready !== 1'b1);
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      exp_q.push_back(e);
      do_op(FWG_OP_READ, a, 16'h0000);
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      do_op(FWG_OP_RAW_WRITE, a, d);
   endtask
   task automatic unlock(input logic [ADDR_W-1:0] a2, input logic [DATA_W-1:0] cmd);
      wr(22'h555, 16'h00aa);
      wr(a2, 16'h0055);
      wr(22'h555, cmd);
   endtask
   task automatic query;
      for (int k = 0; k < 23; k++) exp_q.push_back(flash.QTAB[k]);
      do_op(FWG_OP_QUERY, '0, '0);
      cmp1("query_ok", 1'b1, o_query_ok);
      cmp1("query_mode", 1'b1, o_query_mode);
   endtask

   // *****************************************
   // Result watcher and hang limit
   // *****************************************
   always @(posedge i_clk) begin
      cyc++;
      if (o_rd_valid === 1'b1) begin
         if (exp_q.size() == 0) cmp1("rd_valid", 1'b0, o_rd_valid);
         else cmp16("rd_data", exp_q.pop_front(), o_rd_data);
      end
      if (cyc == 20000) begin
         errors++;
         report_and_stop();
      end
   end

   initial begin
      i_rstn = 1'b0;
      i_op_valid = 1'b0;
      i_op = FWG_OP_READ;
      i_op_addr = '0;
      i_op_data = '0;
      supply_ok = 1'b1;
      repeat (5) @(posedge i_clk);
      i_rstn <= 1'b1;
      @(posedge i_clk);
      rd(22'h10, initv(22'h10));
      wr(22'h20, 16'h0000);
      rd(22'h20, initv(22'h20));
      // Broken unlock must not program
      unlock(22'h3aa, 16'h00a0);
      wr(22'h30, 16'h0000);
      rd(22'h30, initv(22'h30));
      for (i = 1; i < 5; i++) begin
         ra = ADDR_W'(i * 32'h1000 + {$random(seed)} % 32'h1000);
         rd_d = DATA_W'($random(seed));
         do_op(FWG_OP_PROGRAM, ra, rd_d);
         rd(ra, initv(ra) & rd_d);
      end
      query();
      unlock(22'h2aa, 16'h00a0);
      wr(22'h10, 16'h0000);
      rd(22'h10, 16'h0051);
      do_op(FWG_OP_QUERY_EXIT, '0, '0);
      rd(22'h10, initv(22'h10));
      cmp1("query_mode", 1'b0, o_query_mode);
      unlock(22'h2aa, 16'h0090);
      query();
      do_op(FWG_OP_QUERY_EXIT, '0, '0);
      rd(22'h0, flash.AUTO_WORD);
      wr(22'h0, 16'h00f0);
      do_op(FWG_OP_ENTER_SEC, '0, '0);
      cmp1("secured_mode", 1'b1, o_secured_mode);
      for (i = 0; i < 8; i++) rd(ADDR_W'(i), flash.serial_word(i));
      do_op(FWG_OP_PROGRAM, 22'h3, 16'h0000);
      rd(22'h3, flash.serial_word(3));
      do_op(FWG_OP_EXIT_SEC, '0, '0);
      rd(22'h3, initv(22'h3));
      cmp1("secured_mode", 1'b0, o_secured_mode);
      supply_ok <= 1'b0;
      do_op(FWG_OP_PROGRAM, 22'h40, 16'h0000);
      supply_ok <= 1'b1;
      rd(22'h40, initv(22'h40));
      i_rstn <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_rstn <= 1'b1;
      @(posedge i_clk);
      rd(22'h44, initv(22'h44));
      repeat (4) @(posedge i_clk);
      cmp1("queue_empty", 1'b1, exp_q.size() == 0);
      report_and_stop();
   end
endmodule // test_fwg_host

bind fwg_host fwg_host_properties chk (.i_clk(i_clk), .i_rstn(i_rstn),
   .o_op_ready(o_op_ready), .o_rd_valid(o_rd_valid), .o_addr(o_addr), .o_dq(o_dq),
   .o_dq_oe(o_dq_oe), .o_ce_n(o_ce_n), .o_we_n(o_we_n), .o_oe_n(o_oe_n));
